/* design/pmbus_cmd_consts.vh */
// constants for the telemetry and identification command set
`ifndef PMBUS_CMD_CONSTS_VH
`define PMBUS_CMD_CONSTS_VH
`define CMD_IOUT        8'h8c
`define CMD_TEMP        8'h8d
`define CMD_FREQ        8'h95
`define CMD_SPEC_REV    8'h98
`define CMD_MAKER_ID    8'h99
`define CMD_MODEL       8'h9a
`define CMD_MAKER_REV   8'h9b
`define CMD_SERIAL      8'h9e
`define CMD_VOUT_FLOOR  8'ha4
`define CMD_VOUT_CEIL   8'ha5
`define CMD_CHIP_TYPE   8'had
`define CMD_CHIP_REV    8'hae
`define EXP_IOUT        5'h1c
`define EXP_UNITY       5'h00
`define SPEC_REV_VAL    8'h33
`define BLOCK_COUNT     8'h01
`define VOUT_FLOOR_VAL  16'h0100
`define VOUT_CEIL_VAL   16'h0b01
`define UNSUP_BIT       7
`endif

/* design/pmbus_telemetry_id_commands.v */
// telemetry and identification command responder behind the bus protocol engine
// Operation
// - command 8c returns output current, linear11, exponent 11100b
// - output current read not acknowledged unless regulating
// - command 8d returns temperature, linear11, exponent zero, signed mantissa
// - command 95 returns switching frequency, exponent zero, unsigned 1 kHz
// - frequency read acknowledged only while regulating
// - command 98 one read-only byte, upper and lower nibble revision codes
// - specification revision byte always reads 33 hex
// - command 99 block read/write, count one then maker id byte
// - command 9a block read/write, count one then model byte
// - command 9b block read/write, count one then maker revision byte
// - command 9e block read/write, count one then serial byte
// - store-all copies the four identification bytes into nonvolatile storage
// - command a4 read-only, returns 0100 hex, 0.5 V
// - command a5 read-only, returns 0b01 hex, 5.5 V
// - command ad block read, count one then chip type byte
// - command ae block read, count one then chip revision byte
// - unsupported command sets bit 7 of communication status
`timescale 1ns/1ps
`include "pmbus_cmd_consts.vh"
module pmbus_telemetry_id_commands #(
	parameter [7:0] CHIP_TYPE = 8'h5a, // arbitrary value
	parameter [7:0] CHIP_REV  = 8'h01, // arbitrary value
	parameter [7:0] ID_INIT   = 8'h00  // arbitrary value
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// command strobes from the protocol engine, same clock
	input  wire        cmd_valid,
	input  wire        cmd_write,
	input  wire [7:0]  cmd_code,
	input  wire [15:0] cmd_wdata,
	input  wire        store_all,
	input  wire        cml_clear,
	// answer to the protocol engine
	output reg         rsp_valid,
	output reg         rsp_ack,
	output reg  [15:0] rsp_data,
	output reg  [1:0]  rsp_len,
	output reg  [7:0]  cml_status,
	// measurements and state from the regulator, asynchronous
	input  wire        regulating,
	input  wire [10:0] iout_raw,
	input  wire [10:0] temp_raw,
	input  wire [10:0] freq_raw,
	// nonvolatile copy of identification bytes
	output reg  [31:0] nvm_data,
	output reg         nvm_write
);
	// byte counts returned on the answer
	localparam [1:0] LEN_NONE   = 2'h0;
	localparam [1:0] LEN_BYTE   = 2'h1;
	localparam [1:0] LEN_WORD   = 2'h2;

	// one-hot selects of the identification entries
	localparam [3:0] SEL_MAKER  = 4'h1;
	localparam [3:0] SEL_MODEL  = 4'h2;
	localparam [3:0] SEL_REV    = 4'h4;
	localparam [3:0] SEL_SERIAL = 4'h8;

	// synchroniser stages for the asynchronous regulator inputs
	reg         reg_s1_r;
	reg         reg_s2_r;
	reg  [10:0] iout_s1_r;
	reg  [10:0] iout_s2_r;
	reg  [10:0] temp_s1_r;
	reg  [10:0] temp_s2_r;
	reg  [10:0] freq_s1_r;
	reg  [10:0] freq_s2_r;

	// identification entries and their one-hot select
	wire [7:0]  id_byte [0:3];
	reg  [3:0]  id_sel;
	wire        id_wr;

	// command class from the decoder
	reg         ro_hit;
	reg         id_hit;
	reg         gated;
	wire        unsup;
	wire        refused;

	// read value and byte count for the current code
	reg  [15:0] rd_val;
	reg  [1:0]  rd_len;

	// next values of the answer registers
	reg         ack_nxt;
	reg  [15:0] data_nxt;
	reg  [1:0]  len_nxt;

	// next values of the status flag and the snapshot
	reg         unsup_nxt;
	reg  [31:0] snap_nxt;
	genvar      g;

	// regulating level; only the second flop is read
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_s1_r <= 1'h0;
			reg_s2_r <= 1'h0;
		end else begin
			reg_s1_r <= regulating;
			reg_s2_r <= reg_s1_r;
		end
	end

	// output current; a sample may tear on a change, the next read settles it
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			iout_s1_r <= 11'h000;
			iout_s2_r <= 11'h000;
		end else begin
			iout_s1_r <= iout_raw;
			iout_s2_r <= iout_s1_r;
		end
	end

	// temperature, same limitation as the current
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_s1_r <= 11'h000;
			temp_s2_r <= 11'h000;
		end else begin
			temp_s1_r <= temp_raw;
			temp_s2_r <= temp_s1_r;
		end
	end

	// switching frequency, same limitation as the current
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_s1_r <= 11'h000;
			freq_s2_r <= 11'h000;
		end else begin
			freq_s1_r <= freq_raw;
			freq_s2_r <= freq_s1_r;
		end
	end

	// command class: read-only, identification entry, or unknown
	always @* begin
		ro_hit = 1'h0;
		id_hit = 1'h0;
		gated  = 1'h0;
		id_sel = 4'h0;
		case (cmd_code)
		`CMD_IOUT: begin
			ro_hit = 1'h1;
			gated  = 1'h1;
		end
		`CMD_TEMP:       ro_hit = 1'h1;
		`CMD_FREQ: begin
			ro_hit = 1'h1;
			gated  = 1'h1;
		end
		`CMD_SPEC_REV:   ro_hit = 1'h1;
		`CMD_MAKER_ID: begin
			id_hit = 1'h1;
			id_sel = SEL_MAKER;
		end
		`CMD_MODEL: begin
			id_hit = 1'h1;
			id_sel = SEL_MODEL;
		end
		`CMD_MAKER_REV: begin
			id_hit = 1'h1;
			id_sel = SEL_REV;
		end
		`CMD_SERIAL: begin
			id_hit = 1'h1;
			id_sel = SEL_SERIAL;
		end
		`CMD_VOUT_FLOOR: ro_hit = 1'h1;
		`CMD_VOUT_CEIL:  ro_hit = 1'h1;
		`CMD_CHIP_TYPE:  ro_hit = 1'h1;
		`CMD_CHIP_REV:   ro_hit = 1'h1;
		default:         ro_hit = 1'h0;
		endcase
	end

	// read value and byte count for the current code
	always @* begin
		rd_val = 16'h0000;
		rd_len = LEN_WORD;
		case (cmd_code)
		`CMD_IOUT:       rd_val = {`EXP_IOUT, iout_s2_r};
		`CMD_TEMP:       rd_val = {`EXP_UNITY, temp_s2_r};
		`CMD_FREQ:       rd_val = {`EXP_UNITY, freq_s2_r};
		`CMD_SPEC_REV: begin
			rd_val = {8'h00, `SPEC_REV_VAL};
			rd_len = LEN_BYTE;
		end
		`CMD_MAKER_ID:   rd_val = {id_byte[0], `BLOCK_COUNT};
		`CMD_MODEL:      rd_val = {id_byte[1], `BLOCK_COUNT};
		`CMD_MAKER_REV:  rd_val = {id_byte[2], `BLOCK_COUNT};
		`CMD_SERIAL:     rd_val = {id_byte[3], `BLOCK_COUNT};
		`CMD_VOUT_FLOOR: rd_val = `VOUT_FLOOR_VAL;
		`CMD_VOUT_CEIL:  rd_val = `VOUT_CEIL_VAL;
		`CMD_CHIP_TYPE:  rd_val = {CHIP_TYPE, `BLOCK_COUNT};
		`CMD_CHIP_REV:   rd_val = {CHIP_REV, `BLOCK_COUNT};
		default:         rd_val = 16'h0000;
		endcase
	end

	// unknown codes are refused and flagged; gated reads need regulation
	assign unsup   = !ro_hit && !id_hit;
	assign refused = unsup || (gated && !reg_s2_r);
	// writes land only in identification entries, read-only codes drop them
	assign id_wr   = cmd_valid && cmd_write && id_hit;

	// one byte per identification entry, taken from the high data byte
	generate
		for (g = 0; g < 4; g = g + 1) begin : id_entry
			reg [7:0] entry_r;
			always @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n)
					entry_r <= ID_INIT;
				else if (id_wr && id_sel[g])
					entry_r <= cmd_wdata[15:8];
			end
			assign id_byte[g] = entry_r;
		end
	endgenerate

	// answer next values; a read-only write is acked (8c and 95 only while regulating) but changes nothing
	always @* begin
		ack_nxt  = 1'h0;
		data_nxt = rsp_data;
		len_nxt  = rsp_len;
		if (cmd_valid) begin
			ack_nxt = !refused;
			if (cmd_write) begin
				data_nxt = 16'h0000;
				len_nxt  = LEN_NONE;
			end else begin
				data_nxt = rd_val;
				len_nxt  = rd_len;
			end
		end
	end

	// handshake pulses stand one cycle, one cycle after the command
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'h0;
			rsp_ack   <= 1'h0;
		end else begin
			rsp_valid <= cmd_valid;
			rsp_ack   <= ack_nxt;
		end
	end

	// data and length stand until the next command
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_data <= 16'h0000;
			rsp_len  <= LEN_NONE;
		end else begin
			rsp_data <= data_nxt;
			rsp_len  <= len_nxt;
		end
	end

	// not-supported flag; a new unsupported command wins over a clear in the same cycle
	always @* begin
		unsup_nxt = cml_status[`UNSUP_BIT];
		if (cml_clear)
			unsup_nxt = 1'h0;
		if (cmd_valid && unsup)
			unsup_nxt = 1'h1;
	end

	// status register; the other bits belong to other blocks and read zero
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			cml_status <= 8'h00;
		else
			cml_status[`UNSUP_BIT] <= unsup_nxt;
	end

	// store-all snapshot of the four identification bytes
	always @* begin
		snap_nxt = nvm_data;
		if (store_all)
			snap_nxt = {id_byte[3], id_byte[2], id_byte[1], id_byte[0]};
	end

	// nonvolatile copy and its one-cycle write pulse
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_data  <= 32'h0000_0000;
			nvm_write <= 1'h0;
		end else begin
			nvm_data  <= snap_nxt;
			nvm_write <= store_all;
		end
	end
endmodule

/* sim/pmbus_host_model.sv */
// host side model that issues one command per call
`timescale 1ns/1ps
module pmbus_host_model (
	// clock
	input  wire         ref_clk,
	// command strobes
	output logic        cmd_valid,
	output logic        cmd_write,
	output logic [7:0]  cmd_code,
	output logic [15:0] cmd_wdata
);
	// idle until the first call
	initial begin
		{cmd_valid, cmd_write, cmd_code, cmd_wdata} = 26'h0;
	end
	// always count one then the byte, so id codes go as block transfers
	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] b);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_code  <= c;
		cmd_wdata <= {b, 8'h01};
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		cmd_code  <= ~c; // stale code must not look valid
	endtask
endmodule

/* sim/pmbus_cmd_checker_properties.sv */
// port assertions for the command responder
`timescale 1ns/1ps
module pmbus_cmd_checker (
	// clock and reset
	input wire        ref_clk,
	input wire        rst_n,
	// command in, answer out
	input wire        cmd_valid,
	input wire        cmd_write,
	input wire [7:0]  cmd_code,
	input wire        rsp_valid,
	input wire        rsp_ack,
	input wire [15:0] rsp_data,
	input wire [1:0]  rsp_len,
	input wire [7:0]  cml_status,
	// regulator state, asynchronous
	input wire        regulating
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// read strobe and block-format codes
	wire rd  = cmd_valid && !cmd_write;
	wire blk = cmd_code inside {8'h99, 8'h9a, 8'h9b, 8'h9e, 8'had, 8'hae};
	a_answer_next: assert property (cmd_valid |=> rsp_valid) else $error("late answer");
	a_iout_form: assert property (
		rd && cmd_code == 8'h8c |=> !rsp_ack || rsp_data[15:11] == 5'h1c) else $error("iout");
	a_temp_form: assert property (
		rd && cmd_code == 8'h8d |=> rsp_ack && rsp_data[15:11] == 5'h00) else $error("temp");
	a_freq_form: assert property (
		rd && cmd_code == 8'h95 |=> !rsp_ack || rsp_data[15:11] == 5'h00) else $error("freq");
	a_rev_byte: assert property (
		rd && cmd_code == 8'h98 |=> rsp_data[7:0] == 8'h33 && rsp_len == 2'd1) else $error("rev");
	a_floor_const: assert property (
		rd && cmd_code == 8'ha4 |=> rsp_data == 16'h0100) else $error("floor");
	a_ceil_const: assert property (
		rd && cmd_code == 8'ha5 |=> rsp_data == 16'h0b01) else $error("ceiling");
	a_block_count: assert property (
		rd && blk |=> rsp_ack && rsp_data[7:0] == 8'h01) else $error("count byte");
	a_unsup_flag: assert property (
		cmd_valid && cmd_code == 8'h00 |=> !rsp_ack && cml_status[7]) else $error("unsupported");
	a_gated_refuse: assert property (
		rd && (cmd_code == 8'h8c || cmd_code == 8'h95) && !$past(regulating, 2) |=> !rsp_ack)
		else $error("gated read acked");
endmodule
bind pmbus_telemetry_id_commands pmbus_cmd_checker pmbus_cmd_checker_inst (
	.ref_clk    (ref_clk),
	.rst_n      (rst_n),
	.cmd_valid  (cmd_valid),
	.cmd_write  (cmd_write),
	.cmd_code   (cmd_code),
	.rsp_valid  (rsp_valid),
	.rsp_ack    (rsp_ack),
	.rsp_data   (rsp_data),
	.rsp_len    (rsp_len),
	.cml_status (cml_status),
	.regulating (regulating)
);

/* sim/pmbus_telemetry_id_commands_test.sv */
// self-checking bench for the command responder
`timescale 1ns/1ps
module pmbus_telemetry_id_commands_test;
	logic        ref_clk, rst_n, store_all, cml_clear, regulating;
	logic [10:0] iout_raw, temp_raw, freq_raw;
	wire         cmd_valid, cmd_write, rsp_valid, rsp_ack, nvm_write;
	wire [7:0]   cmd_code, cml_status;
	wire [15:0]  cmd_wdata, rsp_data;
	wire [1:0]   rsp_len;
	wire [31:0]  nvm_data;
	int          err_count, check_count, i;
	logic [7:0]  cmd_list [4] = '{8'h99, 8'h9a, 8'h9b, 8'h9e};
	pmbus_host_model pmbus_host_model_inst (
		.ref_clk   (ref_clk),
		.cmd_valid (cmd_valid),
		.cmd_write (cmd_write),
		.cmd_code  (cmd_code),
		.cmd_wdata (cmd_wdata)
	);
	pmbus_telemetry_id_commands pmbus_telemetry_id_commands_inst (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.cmd_valid  (cmd_valid),
		.cmd_write  (cmd_write),
		.cmd_code   (cmd_code),
		.cmd_wdata  (cmd_wdata),
		.store_all  (store_all),
		.cml_clear  (cml_clear),
		.rsp_valid  (rsp_valid),
		.rsp_ack    (rsp_ack),
		.rsp_data   (rsp_data),
		.rsp_len    (rsp_len),
		.cml_status (cml_status),
		.regulating (regulating),
		.iout_raw   (iout_raw),
		.temp_raw   (temp_raw),
		.freq_raw   (freq_raw),
		.nvm_data   (nvm_data),
		.nvm_write  (nvm_write)
	);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask
	// answer lands at the edge that ends the strobe
	task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] b);
		pmbus_host_model_inst.xfer(w, c, b);
		#1;
	endtask
	task automatic rd(input logic [7:0] c, input logic [19:0] e);
		cmd(1'b0, c, 8'h00);
		chk({rsp_valid, rsp_ack, rsp_len, rsp_data}, e);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang guard
	initial begin
		#100000;
		err_count++;
		end_sim;
	end
	initial begin
		{rst_n, store_all, cml_clear, regulating} = 4'h0;
		{iout_raw, temp_raw, freq_raw} = {11'h0a0, 11'h7ec, 11'h190};
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		// measurements need two edges through the synchronisers
		repeat (2) @(posedge ref_clk);
		rd(8'h8d, {4'he, 16'h07ec});
		cmd(1'h0, 8'h8c, 8'h00);
		chk({rsp_valid, rsp_ack}, 2'h2);
		cmd(1'h0, 8'h95, 8'h00);
		chk({rsp_valid, rsp_ack}, 2'h2);
		cmd(1'h0, 8'h98, 8'h00);
		chk({rsp_ack, rsp_len, rsp_data}, {1'h1, 2'h1, 16'h0033});
		cmd(1'h1, 8'ha4, 8'hff);
		chk({rsp_valid, rsp_ack, rsp_len}, 4'hc);
		rd(8'ha4, {4'he, 16'h0100});
		rd(8'ha5, {4'he, 16'h0b01});
		rd(8'had, {4'he, 16'h5a01});
		rd(8'hae, {4'he, 16'h0101});
		$display("constants done");
		@(posedge ref_clk);
		regulating <= 1'h1;
		repeat (3) @(posedge ref_clk);
		rd(8'h8c, {4'he, 16'he0a0});
		rd(8'h95, {4'he, 16'h0190});
		$display("telemetry done");
		foreach (cmd_list[k]) begin
			cmd(1'h1, cmd_list[k], 8'h10 + k[7:0]);
			rd(cmd_list[k], {4'he, 8'h10 + k[7:0], 8'h01});
		end
		@(posedge ref_clk);
		store_all <= 1'h1;
		@(posedge ref_clk);
		store_all <= 1'h0;
		#1;
		for (i = 0; i < 4 && nvm_write !== 1'h1; i++) @(posedge ref_clk) #1;
		chk(nvm_write, 1'h1);
		chk(nvm_data, 32'h13121110);
		$display("identification done");
		cmd(1'h0, 8'h00, 8'h00);
		chk({rsp_ack, cml_status[7]}, 2'h1);
		@(posedge ref_clk);
		cml_clear <= 1'h1;
		@(posedge ref_clk);
		cml_clear <= 1'h0;
		#1;
		chk(cml_status[7], 1'h0);
		// a refusal in the same cycle as a clear must win
		fork
			cmd(1'h0, 8'h00, 8'h00);
			begin
				@(posedge ref_clk);
				cml_clear <= 1'h1;
				@(posedge ref_clk);
				cml_clear <= 1'h0;
			end
		join
		chk({rsp_ack, cml_status[7]}, 2'h1);
		$display("unsupported done");
		end_sim;
	end
endmodule
